// ### src/sacc_cfg.svh
// Constants for the converter control block
`ifndef SACC_CFG_SVH
`define SACC_CFG_SVH
`define SACC_RES_W 10
`define SACC_CH_W 4
`define SACC_REF_W 2
`define SACC_TS_W 3
`define SACC_PS_W 3
`define SACC_NTRIG 8
`define SACC_TS_FREE 3'h0
`define SACC_CYC_NORMAL 5'h0d
`define SACC_CYC_FIRST 5'h19
`define SACC_PRE_W 7
`endif

// ### src/sacc_pkg.sv
// Types for the converter control block
package sacc_pkg;
   typedef enum logic [1:0] {SACC_IDLE, SACC_WAIT, SACC_CONV} sacc_state_e;
endpackage

// ### src/sacc_core_if.sv
// Link between the control logic and the analog core stub
`timescale 1ns/10ps
`default_nettype none
`include "sacc_cfg.svh"
interface sacc_core_if;
   logic start;
   logic [4:0] cycles;
   logic adc_tick;
   logic done;
   logic [`SACC_RES_W-1:0] code;
   modport ctrl(output start, output cycles, output adc_tick, input done, input code);
   modport core(input start, input cycles, input adc_tick, output done, output code);
endinterface
`default_nettype wire

// ### src/sacc_core.sv
// Analog core stub: latency of cycles converter clocks, set by the controller at each start
`timescale 1ns/10ps
`default_nettype none
`include "sacc_cfg.svh"
module sacc_core (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [`SACC_RES_W-1:0] sample,
   sacc_core_if.core cif
);
   logic [4:0] cnt_reg;
   logic busy_reg;
   logic done_reg;
   logic [`SACC_RES_W-1:0] code_reg;
   wire last_tick = busy_reg && cif.adc_tick && (cnt_reg == 5'h01);
   assign cif.done = done_reg;
   assign cif.code = code_reg;
   // Count converter ticks; result latched at last tick
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_reg <= 5'h00;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         code_reg <= '0;
      end else begin
         done_reg <= last_tick;
         if (cif.start) begin
            cnt_reg <= cif.cycles;
            busy_reg <= 1'b1;
         end else if (busy_reg && cif.adc_tick) begin
            cnt_reg <= cnt_reg - 5'h01;
            if (cnt_reg == 5'h01) begin
               busy_reg <= 1'b0;
               code_reg <= sample;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### src/sacc_top.sv
// Converter control: start, auto trigger, prescaler, result lock
`timescale 1ns/10ps
`default_nettype none
`include "sacc_cfg.svh"
module sacc_top
   import sacc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic converter_enable_bit,
   input wire logic converter_power_reduction,
   input wire logic start_write,
   input wire logic auto_trigger_enable,
   input wire logic [`SACC_TS_W-1:0] trigger_source_select,
   input wire logic [`SACC_NTRIG-1:0] trigger_lines,
   input wire logic [`SACC_PS_W-1:0] prescale_select,
   input wire logic left_adjust_select,
   input wire logic [`SACC_CH_W-1:0] channel_select_field,
   input wire logic [`SACC_REF_W-1:0] reference_select_field,
   input wire logic flag_clear,
   input wire logic read_low,
   input wire logic read_high,
   input wire logic [`SACC_RES_W-1:0] analog_sample,
   output logic conversion_start_bit,
   output logic conversion_complete_flag,
   output logic [7:0] result_high_byte,
   output logic [7:0] result_low_byte,
   output logic [`SACC_CH_W-1:0] core_channel,
   output logic [`SACC_REF_W-1:0] core_reference,
   output logic core_powered,
   output logic result_locked
);
   sacc_core_if cif ();
   sacc_state_e state_reg, state_next;
   logic [`SACC_NTRIG-1:0] trig_s1_reg, trig_s2_reg;
   logic trig_prev_reg;
   logic first_reg;
   logic [`SACC_PRE_W-1:0] pre_reg;
   logic start_reg;
   logic [4:0] cyc_reg;
   logic [`SACC_RES_W-1:0] res_reg;
   logic [`SACC_CH_W-1:0] ch_reg;
   logic [`SACC_REF_W-1:0] ref_reg;
   logic sbit_reg, flag_reg, lock_reg, pwr_reg;

   // Enable only counts while power reduction is off
   wire enabled = converter_enable_bit && !converter_power_reduction;
   // Synchronised trigger selected, or conversion completion (conv_done, not the flag) for free running
   wire trig_sel = trig_s2_reg[trigger_source_select];
   wire trig_rise = trig_sel && !trig_prev_reg;
   wire free_mode = auto_trigger_enable
                    && (trigger_source_select == `SACC_TS_FREE);
   wire busy = (state_reg != SACC_IDLE);
   // Edges while busy are dropped; only a fresh edge counts
   wire auto_go = auto_trigger_enable && !free_mode && trig_rise && !busy;
   wire sw_go = start_write && !busy;
   wire conv_done = cif.done && (state_reg == SACC_CONV);
   wire free_again = conv_done && free_mode;
   // Prescaler tick: bit chosen by prescale select, reset by trigger
   wire [`SACC_PRE_W-1:0] pre_inc = pre_reg + 7'h01;
   wire adc_tick = enabled && (pre_inc[prescale_select] && !pre_reg[prescale_select]);
   wire [`SACC_RES_W-1:0] res_next = cif.code;
   // Bytes must change in the same cycle the flag rises, so view the incoming code
   wire res_store = conv_done && !lock_reg;
   wire [`SACC_RES_W-1:0] res_now = res_store ? res_next : res_reg;
   // Left adjust places top eight bits in high byte
   wire [15:0] res_left = {res_now, 6'h00};
   wire [15:0] res_right = {6'h00, res_now};
   wire [15:0] res_view = left_adjust_select ? res_left : res_right;

   assign cif.start = start_reg;
   assign cif.cycles = cyc_reg;
   assign cif.adc_tick = adc_tick;

   // Next state of the conversion sequencer
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SACC_IDLE: begin
            if (!enabled) begin
               state_next = SACC_IDLE;
            end else if (auto_go) begin
               state_next = SACC_CONV;
            end else if (sw_go) begin
               state_next = SACC_WAIT;
            end
         end
         SACC_WAIT: begin
            if (!enabled) begin
               state_next = SACC_IDLE;
            end else if (adc_tick) begin
               state_next = SACC_CONV; // Starts on next converter clock edge
            end
         end
         SACC_CONV: begin
            if (!enabled) begin
               state_next = SACC_IDLE;
            end else if (conv_done) begin
               state_next = free_again ? SACC_CONV : SACC_IDLE;
            end
         end
         default: state_next = SACC_IDLE;
      endcase
   end

   // Trigger synchronisers; first stage feeds only the second
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         trig_s1_reg <= '0;
         trig_s2_reg <= '0;
         trig_prev_reg <= 1'b0;
      end else begin
         trig_s1_reg <= trigger_lines;
         trig_s2_reg <= trig_s1_reg;
         trig_prev_reg <= trig_sel;
      end
   end

   // Prescaler, cleared while disabled and on accepted trigger
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pre_reg <= '0;
      end else if (!enabled || auto_go) begin
         pre_reg <= '0;
      end else begin
         pre_reg <= pre_inc;
      end
   end

   // Core start strobe and length: first conversion after enable is long, and so is a free-running restart right after it (cyc_reg lags first_reg)
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= SACC_IDLE;
         start_reg <= 1'b0;
         cyc_reg <= `SACC_CYC_NORMAL;
         first_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         start_reg <= (state_next == SACC_CONV)
                      && ((state_reg != SACC_CONV) || free_again);
         if (!enabled) begin
            first_reg <= 1'b1;
         end else if (conv_done) begin
            first_reg <= 1'b0;
         end
         cyc_reg <= first_reg ? `SACC_CYC_FIRST : `SACC_CYC_NORMAL;
      end
   end

   // Selections follow inputs while enabled, held only while the sequencer stays in conversion
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ch_reg <= '0;
         ref_reg <= '0;
         pwr_reg <= 1'b0;
      end else begin
         pwr_reg <= enabled;
         if (enabled && (state_next != SACC_CONV || state_reg != SACC_CONV)) begin
            ch_reg <= channel_select_field;
            ref_reg <= reference_select_field;
         end
      end
   end

   // Start bit high through any conversion; cleared on return to idle, so it stays high in free running
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sbit_reg <= 1'b0;
      end else begin
         sbit_reg <= (state_next != SACC_IDLE);
      end
   end

   // Completion flag: set wins over clear, set even if discarded
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         flag_reg <= 1'b0;
      end else if (conv_done) begin
         flag_reg <= 1'b1;
      end else if (flag_clear) begin
         flag_reg <= 1'b0;
      end
   end

   // Result lock: low read locks, high read unlocks
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         lock_reg <= 1'b0;
      end else if (read_high) begin
         lock_reg <= 1'b0;
      end else if (read_low) begin
         lock_reg <= 1'b1;
      end
   end

   // Result store skipped while locked
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         res_reg <= '0;
      end else if (res_store) begin
         res_reg <= res_next;
      end
   end

   // Registered outputs; new code shows with the flag, adjust select one cycle later
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         result_high_byte <= 8'h00;
         result_low_byte <= 8'h00;
      end else begin
         result_high_byte <= res_view[15:8];
         result_low_byte <= res_view[7:0];
      end
   end

   assign conversion_start_bit = sbit_reg;
   assign conversion_complete_flag = flag_reg;
   assign core_channel = ch_reg;
   assign core_reference = ref_reg;
   assign core_powered = pwr_reg;
   assign result_locked = lock_reg;

   sacc_core u_core (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .sample(analog_sample),
      .cif(cif)
   );
endmodule
`default_nettype wire

// ### tb/sacc_trig_model.sv
// Trigger source model for the auto trigger inputs
`timescale 1ns/10ps
`default_nettype none
module sacc_trig_model (
   input wire logic [2:0] line_sel,
   input wire logic level,
   output logic [7:0] trigger_lines
);
   // Lines that are not chosen stay low, so only the chosen source can give an edge
   assign trigger_lines = level ? (8'h01 << line_sel) : 8'h00;
endmodule
`default_nettype wire

// ### tb/sacc_top_asserts.sv
// Port checker for the converter control block
`timescale 1ns/10ps
`default_nettype none
module sacc_chk (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic converter_enable_bit,
   input wire logic converter_power_reduction,
   input wire logic start_write,
   input wire logic flag_clear,
   input wire logic read_low,
   input wire logic read_high,
   input wire logic left_adjust_select,
   input wire logic conversion_start_bit,
   input wire logic conversion_complete_flag,
   input wire logic [7:0] result_high_byte,
   input wire logic [7:0] result_low_byte,
   input wire logic core_powered,
   input wire logic result_locked
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // Enable as the core sees it; power reduction overrides the enable bit
   wire en = converter_enable_bit && !converter_power_reduction;
   // A started conversion, then its completion within the slowest allowed span
   sequence s_go;
      $rose(conversion_start_bit) && en;
   endsequence
   sequence s_end;
      ##[20:1000] $rose(conversion_complete_flag);
   endsequence
   AST_END_BOUNDED: assert property (s_go |-> s_end)
      else $error("conversion never completed");
   AST_MIN_RUN: assert property (s_go |=> conversion_start_bit [*8])
      else $error("start bit dropped early");
   AST_START: assert property (start_write && en && core_powered && !conversion_start_bit
      |=> conversion_start_bit) else $error("start write ignored");
   AST_END_FLAG: assert property ($fell(conversion_start_bit) && en && $past(en)
      |-> conversion_complete_flag) else $error("end without flag");
   AST_FLAG_CLEAR: assert property (flag_clear && !conversion_start_bit
      |=> !conversion_complete_flag) else $error("flag not cleared");
   AST_LOCK: assert property (read_low && !read_high |=> result_locked)
      else $error("low read did not lock");
   AST_UNLOCK: assert property (read_high |=> !result_locked)
      else $error("high read did not unlock");
   AST_HOLD: assert property ($past(result_locked) && result_locked
      |-> $stable(result_high_byte) && $stable(result_low_byte))
      else $error("bytes changed while locked");
   AST_OFF: assert property (!converter_enable_bit [*2]
      |-> !conversion_start_bit && !core_powered) else $error("busy while off");
   AST_LEFT: assert property ($past(left_adjust_select) && left_adjust_select
      |-> result_low_byte[5:0] == 6'h00) else $error("left view wrong");
endmodule
bind sacc_top sacc_chk i_sacc_chk (.*);
`default_nettype wire

// ### tb/sacc_top_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
`include "sacc_cfg.svh"
`define CHK(nm, ex, got) begin \
   total_checks++; \
   if ((got) !== (ex)) begin \
      err_total++; \
      $display("[ERR] %s exp %0h got %0h", nm, ex, got); \
   end \
end
module sacc_top_tb;
   logic sys_clk = 1'h0, reset_n = 1'h0, converter_enable_bit = 1'h0;
   logic converter_power_reduction = 1'h1, start_write = 1'h0, auto_trigger_enable = 1'h0;
   logic left_adjust_select = 1'h0, flag_clear = 1'h0, read_low = 1'h0, read_high = 1'h0;
   logic level = 1'h0;
   logic [2:0] trigger_source_select = 3'h0, prescale_select = 3'h0, line_sel = 3'h0;
   logic [`SACC_CH_W-1:0] channel_select_field = 4'h0, core_channel;
   logic [`SACC_REF_W-1:0] reference_select_field = 2'h0, core_reference;
   logic [`SACC_RES_W-1:0] analog_sample = 10'h000;
   logic [`SACC_NTRIG-1:0] trigger_lines;
   logic conversion_start_bit, conversion_complete_flag, core_powered, result_locked;
   logic [7:0] result_high_byte, result_low_byte;
   int err_total = 0, total_checks = 0, n;
   sacc_top i_sacc_top (.*);
   sacc_trig_model i_sacc_trig_model (.*);
   // 125 MHz system clock
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   // Inputs move 1 ns after the edge so the design never races the bench
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   task automatic pulse(ref logic s);
      s = 1'h1;
      cyc(1);
      s = 1'h0;
   endtask
   // Bounded wait, so a dead core ends in a mismatch rather than a hang
   task automatic wait_flag(output int k);
      k = 0;
      while (conversion_complete_flag !== 1'h1 && k < 2000) begin
         cyc(1);
         k++;
      end
      `CHK("flag", 1'h1, conversion_complete_flag)
   endtask
   task automatic conv(input logic [`SACC_RES_W-1:0] v);
      analog_sample = v;
      pulse(flag_clear);
      pulse(start_write);
      wait_flag(n);
   endtask
   task automatic t_single;
      int n1;
      converter_power_reduction = 1'h0;
      converter_enable_bit = 1'h1;
      cyc(2);
      analog_sample = 10'h2a5;
      pulse(start_write);
      `CHK("start bit", 1'h1, conversion_start_bit)
      wait_flag(n1);
      `CHK("start end", 1'h0, conversion_start_bit)
      `CHK("right high", 8'h02, result_high_byte)
      `CHK("right low", 8'ha5, result_low_byte)
      conv(10'h2a5);
      `CHK("first longer", 1'h1, n1 >= 48 && n < n1 && n >= 24)
   endtask
   task automatic t_lock;
      left_adjust_select = 1'h1;
      conv(10'h3c1);
      `CHK("left high", 8'hf0, result_high_byte)
      `CHK("left low", 8'h40, result_low_byte)
      pulse(read_low);
      `CHK("locked", 1'h1, result_locked)
      conv(10'h155);
      `CHK("kept high", 8'hf0, result_high_byte)
      `CHK("kept low", 8'h40, result_low_byte)
      pulse(read_high);
      conv(10'h155);
      `CHK("new high", 8'h55, result_high_byte)
      left_adjust_select = 1'h0;
   endtask
   task automatic t_chan;
      converter_enable_bit = 1'h0;
      channel_select_field = 4'h5;
      reference_select_field = 2'h1;
      cyc(3);
      `CHK("chan off", 4'h0, core_channel)
      converter_enable_bit = 1'h1;
      cyc(3);
      `CHK("chan on", 4'h5, core_channel)
      `CHK("ref on", 2'h1, core_reference)
      pulse(flag_clear);
      pulse(start_write);
      cyc(6);
      channel_select_field = 4'h9;
      cyc(4);
      `CHK("chan held", 4'h5, core_channel)
      wait_flag(n);
      cyc(2);
      `CHK("chan after", 4'h9, core_channel)
   endtask
   task automatic t_trig;
      pulse(flag_clear);
      trigger_source_select = 3'h2;
      line_sel = 3'h2;
      level = 1'h1;
      cyc(8);
      `CHK("auto off", 1'h0, conversion_start_bit)
      level = 1'h0;
      auto_trigger_enable = 1'h1;
      cyc(4);
      level = 1'h1;
      cyc(8);
      `CHK("trig start", 1'h1, conversion_start_bit)
      level = 1'h0;
      cyc(2);
      level = 1'h1;
      wait_flag(n);
      cyc(12);
      `CHK("no restart", 1'h0, conversion_start_bit)
      level = 1'h0;
      pulse(flag_clear);
      pulse(start_write);
      `CHK("sw start", 1'h1, conversion_start_bit)
      wait_flag(n);
   endtask
   task automatic t_free;
      trigger_source_select = 3'h0;
      pulse(flag_clear);
      pulse(start_write);
      wait_flag(n);
      cyc(3);
      `CHK("free busy", 1'h1, conversion_start_bit)
      pulse(flag_clear);
      wait_flag(n);
      converter_enable_bit = 1'h0;
      cyc(3);
      `CHK("off idle", 1'h0, conversion_start_bit)
      `CHK("off power", 1'h0, core_powered)
   endtask
   task automatic give_verdict;
      if (err_total == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Main sequence: reset held for 3 clocks, then the scenarios in turn
   initial begin
      cyc(3);
      reset_n = 1'h1;
      cyc(1);
      t_single;
      t_lock;
      t_chan;
      t_trig;
      t_free;
      give_verdict;
   end
   // The run needs well under 1000 cycles; 2500 cycles means something hung
   initial begin
      #20000;
      err_total++;
      give_verdict;
   end
endmodule
`default_nettype wire
